/* File: swsq_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// sweep cycle sequencer top
// ------------------------------------------------------------
module swsq_sequencer
    import swsq_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [RATE_W-1:0] rate_code,        // latched rate code, D3 at bit 0
    input  wire swsq_trig_t        trig_source,      // latched trigger source
    input  wire logic              free_run,         // 1 = free run, 0 = triggered
    input  wire logic              holdoff_done,     // holdoff timer finished
    input  wire swsq_async_t       async_in,         // comparators and triggers
    output var  logic              display_blank_gate, // high = display shown
    output var  logic              pen_raise,        // high = plotter pen up
    output var  logic              reset_clamp,      // integrator discharge
    output var  logic              holdoff_start,    // high while holdoff runs
    output var  logic              sweep_start,      // start multiplexer output
    output var  logic              trig_flop,        // trigger flip-flop state
    output var  swsq_analog_t      analog_ctl        // capacitor/resistor switches
);

    // ------------------------------------------------------------
    // operation overview
    // ------------------------------------------------------------
    // retrace: sweep-state flop set, clamp on, display blanked,
    //          holdoff runs until the external timer reports done
    // armed:   start multiplexer enabled; free run starts at once,
    //          triggered mode waits for a rising selected trigger
    // sweep:   clamp off, ramp climbs; right-of-screen lifts the pen,
    //          end-of-sweep sets the flop again and restarts holdoff
    // analog:  manual level or external input drives the integrator
    //          as an amplifier; the flop is held reset meanwhile
    // every comparator and trigger arrives two clocks late through
    //          the synchroniser, so a trigger narrower than one clock
    //          period can be missed; stretch such pulses upstream
    // trigger flop: cleared by the first armed edge, set again as the
    //          sweep begins, ready for the next holdoff-trigger cycle
    // limitation: trigger source code three selects nothing, so the
    //          sequencer then only runs in free run
    // outputs lag the internal decision by one clock; the clamp and
    //          blank gate always move on the same edge, the pen also moves alone at right-of-screen
    // holdoff length is not timed here: the external timer owns it,
    //          and its done level is sampled on every clock
    // a rate code change mid-sweep to another ramp code only retunes the
    //          analog switches; a change to manual or external enters the analog phase

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] synced;      // registered copies of async_in
    swsq_sync u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .raw     (async_in),
        .synced  (synced)
    );
    swsq_async_t s_in;              // synced, named fields
    assign s_in = swsq_async_t'(synced);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // one-hot resistor or input line from the rate code
    function automatic logic [RES_SEL_W-1:0] res_decode(input logic [RATE_W-1:0] code);
        logic [RES_SEL_W-1:0] sel;
        sel = '0;
        if (code == RATE_EXTERNAL)
            sel[RES_EXT_IN] = 1'b1;
        else
            sel[code[RES_MSB:RES_LSB]] = 1'b1;
        return sel;
    endfunction : res_decode

    // manual scan or external sweep selected
    function automatic logic is_analog(input logic [RATE_W-1:0] code);
        return (code == RATE_MANUAL) || (code == RATE_EXTERNAL);
    endfunction : is_analog

    // ------------------------------------------------------------
    // trigger source multiplexer and edge detect
    // ------------------------------------------------------------
    logic trig_sel;                 // selected trigger level
    logic trig_prev;                // last selected level
    logic trig_rise;                // rising edge of selected trigger

    always_comb begin
        case (trig_source)
            SWSQ_TRIG_VIDEO: trig_sel = s_in.trig_video;
            SWSQ_TRIG_EXT:   trig_sel = s_in.trig_ext;
            SWSQ_TRIG_LINE:  trig_sel = s_in.trig_line;
            default:         trig_sel = 1'b0;               // unused code: no trigger
        endcase
        trig_rise = trig_sel & ~trig_prev;
    end

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    swsq_state_t  state, next_state;
    logic         next_blank, next_pen, next_clamp, next_holdoff;
    logic         next_start, next_trig_flop;
    logic         mux_enable;       // start multiplexer enabled
    logic         analog_mode;      // manual / external
    swsq_analog_t next_analog;

    always_comb begin
        analog_mode    = is_analog(rate_code);
        mux_enable     = (state == SWSQ_ARMED);
        next_state     = state;
        next_trig_flop = trig_flop;
        next_start     = 1'b0;                              // low unless enabled
        next_holdoff   = holdoff_start;
        case (state)
            SWSQ_RETRACE: begin                             // clamp on, holdoff runs
                next_holdoff = 1'b1;
                if (holdoff_done) begin
                    next_state   = SWSQ_ARMED;
                    next_holdoff = 1'b0;
                end
            end
            SWSQ_ARMED: begin
                // trigger flop only clears on an edge once enabled
                if (mux_enable && trig_rise) begin
                    next_trig_flop = 1'b0;
                end
                // free run passes a constant high, else the trigger
                if (mux_enable && (free_run || trig_rise)) begin
                    next_start = 1'b1;
                    next_state = SWSQ_SWEEP;
                end
            end
            SWSQ_SWEEP: begin
                next_trig_flop = 1'b1;                      // re-arm on start
                next_start     = 1'b0;
                // end of sweep sets the flop and starts holdoff together
                if (s_in.end_of_sweep) begin
                    next_state   = SWSQ_RETRACE;
                    next_holdoff = 1'b1;
                end
            end
            SWSQ_ANALOG: begin                              // amplifier mode
                if (!analog_mode)
                    next_state = SWSQ_RETRACE;
            end
            default: next_state = SWSQ_RETRACE;
        endcase
        // manual/external overrides state, start and holdoff; flop held reset
        if (analog_mode) begin
            next_state   = SWSQ_ANALOG;
            next_start   = 1'b0;
            next_holdoff = 1'b0;
        end
        // outputs follow the sweep-state flop (set in RETRACE/ARMED)
        next_clamp = (next_state == SWSQ_RETRACE) || (next_state == SWSQ_ARMED);
        next_blank = ~next_clamp;
        // pen up whenever blanked, or in sweep past right edge of screen
        next_pen   = ~next_blank || (next_state == SWSQ_SWEEP && s_in.right_of_screen);
        if (next_state == SWSQ_ANALOG)
            next_pen = 1'b0;                                // gate high, pen down
        // analog switches
        next_analog.res_sel     = res_decode(rate_code);
        next_analog.feedback_on = analog_mode;
        next_analog.cap_mid_on  = !analog_mode &&
            (rate_code[CAP_MSB:CAP_LSB] == CAP_MID || rate_code[CAP_MSB:CAP_LSB] == CAP_SLOW);
        next_analog.cap_slow_on = !analog_mode &&
            (rate_code[CAP_MSB:CAP_LSB] == CAP_SLOW);
    end

    // ------------------------------------------------------------
    // trigger path registers
    // ------------------------------------------------------------
    // reset leaves the trigger flop set and the edge memory at the
    // idle low level of the synced input, so no false edge follows
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trig_prev <= 1'b0;                              // idle level
            trig_flop <= 1'b1;                              // armed
        end else begin
            trig_prev <= trig_sel;
            trig_flop <= next_trig_flop;
        end
    end

    // ------------------------------------------------------------
    // sequencer registers; reset leaves sweep-state flop set
    // ------------------------------------------------------------
    // every output comes straight from a flop, so the blanking gate,
    // pen and clamp change only on a clock edge with no decode glitch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state              <= SWSQ_RETRACE;
            sweep_start        <= 1'b0;                     // start mux quiet
            holdoff_start      <= 1'b1;                     // holdoff from reset
            display_blank_gate <= 1'b0;
            pen_raise          <= 1'b1;
            reset_clamp        <= 1'b1;
        end else begin
            state              <= next_state;
            sweep_start        <= next_start;               // one-cycle pulse
            holdoff_start      <= next_holdoff;
            display_blank_gate <= next_blank;
            pen_raise          <= next_pen;
            reset_clamp        <= next_clamp;
        end
    end

    // ------------------------------------------------------------
    // analog switch registers
    // ------------------------------------------------------------
    // all switches open during reset; the rate code is re-decoded on
    // every clock, so a new latched code takes effect one edge later
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            analog_ctl <= '0;                               // switches open
        end else begin
            analog_ctl <= next_analog;
        end
    end

endmodule : swsq_sequencer
`default_nettype wire

/* File: swsq_pkg.sv */
//------------------------------------------------------------
//------------------------------------------------------------
`default_nettype none
package swsq_pkg;

    // ------------------------------------------------------------
    // rate code layout (five bits, D3 at bit 0)
    // ------------------------------------------------------------
    localparam int RATE_W         = 5;
    localparam int CAP_LSB        = 0;       // D3
    localparam int CAP_MSB        = 1;       // D4
    localparam int RES_LSB        = 2;       // D5
    localparam int RES_MSB        = 4;       // D7
    localparam int RES_W          = 3;
    localparam int RES_SEL_W      = 8;       // one-hot resistor / input lines
    localparam int SYNC_W         = 5;       // synchronised inputs

    localparam logic [1:0] CAP_FAST   = 2'h3;  // 20 us .. 1 ms
    localparam logic [1:0] CAP_MID    = 2'h1;  // 2 ms .. 100 ms
    localparam logic [1:0] CAP_SLOW   = 2'h0;  // 200 ms .. 10 s
    localparam logic [4:0] RATE_MANUAL   = 5'h1F;
    localparam logic [4:0] RATE_EXTERNAL = 5'h0F;  // D7 low, D6..D3 high
    localparam logic [2:0] RES_MANUAL_IN = 3'h7;  // manual level line
    localparam logic [2:0] RES_EXT_IN    = 3'h3;  // external horizontal line

    // trigger source selection
    typedef enum logic [1:0] {
        SWSQ_TRIG_VIDEO,
        SWSQ_TRIG_EXT,
        SWSQ_TRIG_LINE
    } swsq_trig_t;

    // sequencer phases
    typedef enum logic [1:0] {
        SWSQ_RETRACE,
        SWSQ_ARMED,
        SWSQ_SWEEP,
        SWSQ_ANALOG
    } swsq_state_t;

    // raw asynchronous inputs as one group
    typedef struct packed {
        logic trig_video;
        logic trig_ext;
        logic trig_line;
        logic right_of_screen;   // ramp past about +7.4 V
        logic end_of_sweep;      // ramp past about +8 V
    } swsq_async_t;

    // analog switch controls as one group
    typedef struct packed {
        logic                 cap_mid_on;
        logic                 cap_slow_on;
        logic                 feedback_on;
        logic [RES_SEL_W-1:0] res_sel;
    } swsq_analog_t;

endpackage : swsq_pkg
`default_nettype wire

/* File: swsq_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// two-stage synchroniser bank
// ------------------------------------------------------------
module swsq_sync
    import swsq_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [SYNC_W-1:0] raw,
    output var  logic [SYNC_W-1:0] synced
);
    logic [SYNC_W-1:0] stage1;        // first stage, read only by stage two
    logic [SYNC_W-1:0] next_stage1;
    logic [SYNC_W-1:0] next_synced;

    // next values: plain shift
    always_comb begin
        next_stage1 = raw;
        next_synced = stage1;
    end

    // registers; reset clears both stages
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= next_stage1;
            synced <= next_synced;
        end
    end
endmodule : swsq_sync
`default_nettype wire

/* File: swsq_ramp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far side: ramp comparators, holdoff timer
// ----------------------------------------
module swsq_ramp_model
    import swsq_pkg::*;
#(
    parameter int ROS_AT  = 20, // cycles of ramp to right-of-screen
    parameter int EOS_AT  = 30, // cycles of ramp to end-of-sweep
    parameter int HOLD_AT = 8   // holdoff length in cycles
)(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        reset_clamp,
    input  wire logic        holdoff_start,
    input  wire logic        sweep_start,
    input  wire logic [2:0]  trig_raw,
    output var  swsq_async_t async_in,
    output var  logic        holdoff_done
);
    int ramp; // ramp level, counts only while unclamped
    int hold; // elapsed holdoff
    // done stays up until the sweep it enables has begun
    always_ff @(posedge clk_sys) begin
        ramp <= (reset || reset_clamp) ? 0 : ramp + 1;
        hold <= (reset || !holdoff_start) ? 0 : hold + 1;
        if (reset || sweep_start) holdoff_done <= 1'b0;
        else if (hold >= HOLD_AT) holdoff_done <= 1'b1;
    end
    // right-of-screen trips before end-of-sweep whenever ROS_AT is below EOS_AT
    assign async_in = {trig_raw, ramp >= ROS_AT, ramp >= EOS_AT};
endmodule : swsq_ramp_model
`default_nettype wire

/* File: swsq_sequencer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// sequencer port checker
// ----------------------------------------
module swsq_sequencer_assertions
    import swsq_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire logic              display_blank_gate,
    input wire logic              pen_raise,
    input wire logic              reset_clamp,
    input wire logic              holdoff_start,
    input wire logic              sweep_start,
    input wire logic              trig_flop,
    input wire logic [RATE_W-1:0] rate_code,
    input wire swsq_async_t       async_in,
    input wire swsq_analog_t      analog_ctl
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic sweeping; // ramp mode with display shown
    assign sweeping = display_blank_gate && rate_code != RATE_MANUAL && rate_code != RATE_EXTERNAL;
    a_clamp_blank_pair: assert property (reset_clamp != display_blank_gate)
        else $error("clamp and blank gate agree");
    a_pen_when_blank: assert property (!display_blank_gate |-> pen_raise)
        else $error("pen down while blanked");
    a_start_rearms: assert property (sweep_start |=> !sweep_start && trig_flop)
        else $error("start not single or flop not set");
    a_start_gated: assert property (sweep_start |-> !holdoff_start && display_blank_gate && !pen_raise)
        else $error("start during holdoff");
    a_eos_blanks: assert property (sweeping && $rose(async_in.end_of_sweep)
        |-> ##[3:5] reset_clamp && holdoff_start)
        else $error("end of sweep not blanked");
    a_ros_pen_up: assert property (sweeping && $rose(async_in.right_of_screen) |-> ##[3:5] pen_raise)
        else $error("pen not raised");
    a_manual_route: assert property ((rate_code == RATE_MANUAL)[*3] |-> analog_ctl.feedback_on
        && display_blank_gate && analog_ctl.res_sel == (8'h01 << RES_MANUAL_IN))
        else $error("manual routing wrong");
    a_cap_mid: assert property ((rate_code[1:0] == CAP_MID)[*2]
        |-> analog_ctl.cap_mid_on && !analog_ctl.cap_slow_on)
        else $error("capacitor range wrong");
endmodule : swsq_sequencer_assertions
bind swsq_sequencer swsq_sequencer_assertions u_chk (.clk_sys(clk_sys), .reset(reset),
    .display_blank_gate(display_blank_gate), .pen_raise(pen_raise), .reset_clamp(reset_clamp),
    .holdoff_start(holdoff_start), .sweep_start(sweep_start), .trig_flop(trig_flop),
    .rate_code(rate_code), .async_in(async_in), .analog_ctl(analog_ctl));
`default_nettype wire

/* File: test_sweep_cycle_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// sweep sequencer bench
// ----------------------------------------
module test_sweep_cycle_sequencer
    import swsq_pkg::*;
;
    localparam int ROS = 20, EOS = 30, HOLD = 8; // far side timing
    logic clk_sys, reset, free_run, holdoff_done, seen, blank, pen, clamp, hstart, start, flop;
    logic [4:0] rate_code;
    logic [2:0] trig_raw; // video, ext, line
    swsq_trig_t trig_source;
    swsq_async_t async_in;
    swsq_analog_t ana;
    int bad_count, comparisons, cycles;
    logic [4:0] rates [3] = '{5'h19, 5'h18, 5'h1B}; // slowest 10 s code never chosen
    logic [1:0] caps [3] = '{2'h2, 2'h3, 2'h0};     // expected mid, slow, fast
    swsq_sequencer u_dut (.clk_sys(clk_sys), .reset(reset), .rate_code(rate_code), .trig_source(trig_source),
        .free_run(free_run), .holdoff_done(holdoff_done), .async_in(async_in), .display_blank_gate(blank),
        .pen_raise(pen), .reset_clamp(clamp), .holdoff_start(hstart), .sweep_start(start),
        .trig_flop(flop), .analog_ctl(ana));
    swsq_ramp_model #(.ROS_AT(ROS), .EOS_AT(EOS), .HOLD_AT(HOLD)) u_far (.clk_sys(clk_sys), .reset(reset),
        .reset_clamp(clamp), .holdoff_start(hstart), .sweep_start(start), .trig_raw(trig_raw),
        .async_in(async_in), .holdoff_done(holdoff_done));
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t exp %h got %h", $time, exp, got);
        end
    endtask : chk
    // controller latch write
    task automatic set_mode(input logic [4:0] rate, input int src, input logic fr);
        @(negedge clk_sys);
        rate_code = rate;
        trig_source = swsq_trig_t'(src);
        free_run = fr;
    endtask : set_mode
    // two clocks: passes the synchroniser, ends before the start pulse
    task automatic pulse(input int src);
        @(negedge clk_sys);
        trig_raw[2-src] = 1'b1;
        repeat (2) @(negedge clk_sys);
        trig_raw = 3'h0;
    endtask : pulse
    task automatic wait_start(input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clk_sys) #1;
            seen = start === 1'b1;
        end
    endtask : wait_start
    task automatic wait_blank;
        for (int i = 0; i < 80 && blank !== 1'b0; i++) @(posedge clk_sys) #1;
    endtask : wait_blank
    task automatic stop_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // status byte: blank, pen, clamp, start
    function automatic logic [7:0] st();
        return {4'h0, blank, pen, clamp, start};
    endfunction : st
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // hang guard
    initial begin
        forever begin
            @(posedge clk_sys);
            cycles++;
            if (cycles == 3000) begin
                bad_count++;
                stop_test();
            end
        end
    end
    initial begin
        reset = 1'b1;
        rate_code = 5'h1B;
        trig_source = SWSQ_TRIG_VIDEO;
        free_run = 1'b1;
        trig_raw = 3'h0;
        repeat (2) @(negedge clk_sys);
        chk(8'h06, st());
        chk(8'h01, {7'h0, flop});
        reset = 1'b0;
        wait_start(40);
        chk(8'h09, st());
        chk(8'h01, {7'h0, $onehot(ana.res_sel)});
        repeat (ROS + 6) @(posedge clk_sys);
        #1 chk(8'h0C, st());
        wait_blank();
        chk(8'h06, st());
        chk(8'h01, {7'h0, hstart});
        wait_start(HOLD);
        chk(8'h00, {7'h0, seen});
        wait_start(20);
        chk(8'h01, {7'h0, seen});
        // triggered: only the selected source, and never in holdoff
        for (int s = 0; s < 3; s++) begin
            set_mode(rates[s], s, 1'b0);
            wait_blank();
            pulse(s);
            repeat (HOLD) @(negedge clk_sys);
            pulse((s + 1) % 3);
            pulse((s + 2) % 3);
            wait_start(10);
            chk(8'h00, {7'h0, seen});
            pulse(s);
            wait_start(10);
            chk(8'h01, {7'h0, seen});
            chk(8'h00, {7'h0, flop});
            chk({6'h0, caps[s]}, {6'h0, ana.cap_mid_on, ana.cap_slow_on});
            @(posedge clk_sys) #1;
            chk(8'h01, {7'h0, flop});
        end
        // manual level, then external input, replace the resistor
        for (int m = 0; m < 2; m++) begin
            set_mode(m ? RATE_EXTERNAL : RATE_MANUAL, 0, 1'b0);
            repeat (4) @(negedge clk_sys);
            chk(8'h08, st());
            chk(8'h01, {7'h0, ana.feedback_on});
            chk(8'h01 << (m ? RES_EXT_IN : RES_MANUAL_IN), ana.res_sel);
        end
        stop_test();
    end
endmodule : test_sweep_cycle_sequencer
`default_nettype wire
